/* verilog/kme_encoder.sv */
/*
  keyboard matrix encoder: scans 9 columns by 10 rows, debounces,
  and presents a binary key position plus modifier mode.
  assumes the matrix returns active-high row sense for the driven column
  and that shift and control come from plain pins.
*/
// Overview of operation
// R1: debounce each closure before reporting its code
// R2: pin selects lockout or rollover scanning
// R3: seven output lines carry binary key position
// R4: position counts rows first, X0Y0 to X8Y9
// R5: line 9 is lsb, line 1 is msb
// R6: lines 2,3 carry mode: normal/shift/control/both
// R7: scan timed by on-chip oscillator
// R8: any-key-down indicator while a key held
// R9: host translates code via PROM or software
// R10: any-key-down is active high
// R11: one data-ready strobe per new code
`timescale 1ns/1ps
module kme_encoder #(
  parameter int DEB_CYC = kme_pkg::KME_DEB_CYC,
  parameter int SCAN_CYC = kme_pkg::KME_SCAN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // matrix
  output logic [kme_pkg::KME_COLS-1:0] colDrive,
  input wire logic [kme_pkg::KME_ROWS-1:0] rowSense,
  // modifiers and option
  input wire logic shiftKey,
  input wire logic controlKey,
  input wire logic lockoutSel,
  // host outputs
  output logic [kme_pkg::KME_POS_W-1:0] keyPos,
  output logic [1:0] keyMode,
  output logic dataReady,
  output logic anyKeyDown
);
  import kme_pkg::*;
  if (DEB_CYC < 2 || DEB_CYC >= (1 << KME_DEB_W)) begin : g_bad_deb
    $error("bad debounce count");
  end
  // rows lag the column drive by two cycles, so a column must stand three
  if (SCAN_CYC < 3) begin : g_bad_scan
    $error("scan period too short for the row synchronisers");
  end

  kme_scan_if scan ();
  kme_scan_osc #(.PERIOD(SCAN_CYC)) kme_scan_osc_inst (
    .clk(clk),
    .rst(rst),
    .scan(scan)
  );

  // pin synchronisers
  logic [KME_ROWS-1:0] rowMeta, rowSync;
  logic [2:0] pinMeta, pinSync;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rowMeta <= '0;
      rowSync <= '0;
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else begin
      rowMeta <= rowSense;
      rowSync <= rowMeta;
      pinMeta <= {lockoutSel, controlKey, shiftKey};
      pinSync <= pinMeta;
    end
  end
  logic lockout, ctrlS, shiftS;
  assign {lockout, ctrlS, shiftS} = pinSync;

  // scan position and per-key state
  logic [3:0] col, next_col;
  logic [KME_KEYS-1:0] keyDown, next_keyDown;
  logic [KME_KEYS-1:0] seenDown, next_seenDown;
  logic [KME_KEYS-1:0] frameDown, next_frameDown;
  logic [KME_DEB_W-1:0] debCnt, next_debCnt;
  logic [KME_POS_W-1:0] cand, next_cand;
  logic candValid, next_candValid;
  logic [KME_POS_W-1:0] next_keyPos;
  logic [1:0] next_keyMode;
  logic next_dataReady;
  logic [KME_POS_W-1:0] hitPos;
  logic hit;
  logic [3:0] hitRow;
  logic [3:0] candRow, next_candRow;
  logic next_anyKeyDown;
  logic lockFree;

  always_comb begin
    colDrive = '0;
    colDrive[col] = 1'b1;
  end

  // first sensed key of this column not yet reported
  always_comb begin
    hit = 1'b0;
    hitPos = '0;
    hitRow = 4'h0;
    for (int r = KME_ROWS - 1; r >= 0; r--) begin
      if (rowSync[r] && !seenDown[col * KME_ROWS + r]) begin
        hit = 1'b1;
        hitPos = KME_POS_W'(col * KME_ROWS + r); // [R4]
        hitRow = 4'(r);
      end
    end
  end

  // lockout: no new key while another is held or still reported
  assign lockFree = !lockout || (keyDown == '0 && seenDown == '0); // [R2]

  always_comb begin
    next_col = col;
    next_keyDown = keyDown;
    next_seenDown = seenDown;
    next_frameDown = frameDown;
    next_debCnt = debCnt;
    next_cand = cand;
    next_candRow = candRow;
    next_candValid = candValid;
    next_keyPos = keyPos;
    next_keyMode = keyMode;
    next_dataReady = 1'b0;
    if (scan.step && !candValid) begin
      for (int r = 0; r < KME_ROWS; r++) begin
        next_frameDown[col * KME_ROWS + r] = rowSync[r];
      end
      if (hit && lockFree) begin // [R2]
        // column stays driven while the candidate is debounced
        next_cand = hitPos;
        next_candRow = hitRow;
        next_candValid = 1'b1;
        next_debCnt = '0;
      end else if (col == 4'(KME_COLS - 1)) begin
        next_col = 4'h0;
        next_keyDown = next_frameDown;
        next_seenDown = seenDown & next_frameDown;
      end else begin
        next_col = col + 4'h1;
      end
    end
    if (candValid) begin
      if (!rowSync[candRow]) begin
        next_candValid = 1'b0; // released during bounce [R1]
      end else if (debCnt == KME_DEB_W'(DEB_CYC - 1)) begin
        next_candValid = 1'b0;
        next_seenDown[cand] = 1'b1;
        next_keyPos = cand; // [R3] [R5]
        next_keyMode = {ctrlS, shiftS}; // [R6]
        next_dataReady = 1'b1; // [R11]
      end else begin
        next_debCnt = debCnt + KME_DEB_W'(1); // [R1]
      end
    end
    next_anyKeyDown = (next_keyDown != '0); // [R8] [R10]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      col <= 4'h0;
      keyDown <= '0;
      seenDown <= '0;
      frameDown <= '0;
      debCnt <= '0;
      cand <= KME_POS_RST;
      candValid <= 1'b0;
      candRow <= 4'h0;
      keyPos <= KME_POS_RST;
      keyMode <= KME_MODE_RST;
      dataReady <= 1'b0;
      anyKeyDown <= 1'b0;
    end else begin
      col <= next_col;
      keyDown <= next_keyDown;
      seenDown <= next_seenDown;
      frameDown <= next_frameDown;
      debCnt <= next_debCnt;
      cand <= next_cand;
      candValid <= next_candValid;
      candRow <= next_candRow;
      keyPos <= next_keyPos;
      keyMode <= next_keyMode;
      dataReady <= next_dataReady;
      anyKeyDown <= next_anyKeyDown; // [R8] [R10]
    end
  end

  a_strobe_single: assert property (@(posedge clk) disable iff (rst) // [R11]
    dataReady |=> !dataReady) else $error("data ready longer than one cycle");
  a_strobe_pos: assert property (@(posedge clk) disable iff (rst) // [R3]
    dataReady |-> (keyPos == $past(cand))) else $error("position not the debounced candidate");
  a_pos_range: assert property (@(posedge clk) disable iff (rst) // [R4]
    keyPos < 7'(KME_KEYS)) else $error("position out of range");
  a_mode_pins: assert property (@(posedge clk) disable iff (rst) // [R6]
    dataReady |-> keyMode == {$past(ctrlS), $past(shiftS)}) else $error("mode mismatch");
  a_code_stable: assert property (@(posedge clk) disable iff (rst) // [R5]
    !dataReady |-> $stable(keyPos) && $stable(keyMode)) else $error("code moved without strobe");
  a_any_down: assert property (@(posedge clk) disable iff (rst) // [R8]
    $changed(anyKeyDown) |-> $past(scan.step && col == 4'(KME_COLS - 1)))
    else $error("any-key-down moved off a frame end");
  a_debounce_wait: assert property (@(posedge clk) disable iff (rst) // [R1]
    $rose(candValid) |-> !dataReady [*2]) else $error("strobe without debounce");
  a_lockout_hold: assert property (@(posedge clk) disable iff (rst) // [R2]
    $rose(candValid) && lockout |-> $past(keyDown) == '0 && $past(seenDown) == '0)
    else $error("lockout violated");
  a_osc_step: assert property (@(posedge clk) disable iff (rst) // [R7]
    scan.step |=> !scan.step) else $error("scan step too long");
  a_any_high: assert property (@(posedge clk) disable iff (rst) // [R10]
    (keyDown != '0) |-> anyKeyDown) else $error("indicator not high");
  a_drop_released: assert property (@(posedge clk) disable iff (rst) // [R1]
    candValid && !rowSync[candRow] |=> !candValid && !dataReady) else $error("bounced key not dropped");
  a_strobe_held: assert property (@(posedge clk) disable iff (rst) // [R1]
    dataReady |-> $past(rowSync[candRow])) else $error("strobe for a key no longer sensed");
  a_scan_held: assert property (@(posedge clk) disable iff (rst) // [R1]
    candValid |=> $stable(col)) else $error("column moved during debounce");
  a_col_onehot: assert property (@(posedge clk) disable iff (rst) // [R7]
    $onehot(colDrive)) else $error("column drive not one-hot");

  c_strobe: cover property (@(posedge clk) disable iff (rst) dataReady);
  c_lock_block: cover property (@(posedge clk) disable iff (rst) scan.step && hit && !lockFree);
  c_shift_ctrl: cover property (@(posedge clk) disable iff (rst) dataReady && keyMode == 2'b11);
  c_bounce: cover property (@(posedge clk) disable iff (rst) $fell(candValid) && !dataReady);
  c_rollover: cover property (@(posedge clk) disable iff (rst) dataReady && !lockout && anyKeyDown);
endmodule // kme_encoder

/* inc/kme_pkg.sv */
/*
  constants and types shared by the keyboard matrix encoder files.
  assumes a 25 MHz system clock.
*/
package kme_pkg;
  localparam int KME_COLS = 9;
  localparam int KME_ROWS = 10;
  localparam int KME_KEYS = 90;
  localparam int KME_POS_W = 7;
  localparam int KME_CLK_HZ = 25_000_000;
  // scan step period of the internal oscillator, in microseconds
  localparam int KME_SCAN_US = 10;
  localparam int KME_SCAN_CYC = (KME_CLK_HZ / 1_000_000) * KME_SCAN_US;
  // debounce time in milliseconds
  localparam int KME_DEB_MS = 5;
  localparam int KME_DEB_CYC = (KME_CLK_HZ / 1000) * KME_DEB_MS;
  localparam int KME_DEB_W = 18;
  localparam logic [KME_POS_W-1:0] KME_POS_RST = 7'h00;
  localparam logic [1:0] KME_MODE_RST = 2'h0;
  typedef enum logic [1:0] {
    KME_NORMAL = 2'b00,
    KME_SHIFT = 2'b01,
    KME_CONTROL = 2'b10,
    KME_SHIFT_CONTROL = 2'b11
  } kme_mode_type;
endpackage

/* inc/kme_scan_if.sv */
/*
  interface between scan oscillator and the encoder core.
  assumes one clock domain.
*/
`timescale 1ns/1ps
interface kme_scan_if;
  logic step;
  modport osc (output step);
  modport core (input step);
endinterface

/* verilog/kme_scan_osc.sv */
/*
  internal scanning oscillator: one-cycle step pulse every period.
  assumes clk and rst of the encoder.
*/
`timescale 1ns/1ps
module kme_scan_osc #(
  parameter int PERIOD = kme_pkg::KME_SCAN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // step out
  kme_scan_if.osc scan
);
  import kme_pkg::*;
  if (PERIOD < 2 || PERIOD > 65536) begin : g_bad_period
    $error("bad scan period");
  end
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_step;
  always_comb begin
    next_step = (count == 16'(PERIOD - 1));
    next_count = next_step ? 16'h0000 : count + 16'h0001;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      scan.step <= 1'b0;
    end else begin
      count <= next_count;
      scan.step <= next_step; // [R7]
    end
  end
endmodule // kme_scan_osc

/* tb/kme_host_model.sv */
/*
  host model: latches the code on each data-ready strobe.
  assumes the clock of the encoder.
*/
`timescale 1ns/1ps
module kme_host_model (
  // clock
  input wire logic clk,
  // encoder outputs
  input wire logic dataReady,
  input wire logic [kme_pkg::KME_POS_W-1:0] keyPos,
  input wire logic [1:0] keyMode,
  // captured
  output int strobes,
  output logic [8:0] charIndex
);
  import kme_pkg::*;
  int nStrobes = 0;
  assign strobes = nStrobes;
  always @(posedge clk) begin
    if (dataReady === 1'b1) begin
      nStrobes <= nStrobes + 1;
      charIndex <= {keyMode, keyPos};
    end
  end
endmodule // kme_host_model

/* tb/keyboard_matrix_encoder_tb.sv */
/*
  self-checking bench for the keyboard matrix encoder.
  assumes ideal switches and active-high row sense.
*/
`timescale 1ns/1ps
module keyboard_matrix_encoder_tb;
  import kme_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [KME_COLS-1:0] colDrive;
  logic [KME_ROWS-1:0] rowSense;
  logic shiftKey = 1'b0;
  logic controlKey = 1'b0;
  logic lockoutSel = 1'b0;
  logic [KME_POS_W-1:0] keyPos;
  logic [1:0] keyMode;
  logic dataReady;
  logic anyKeyDown;
  logic [KME_KEYS-1:0] keys = '0;
  logic [8:0] charIndex;
  int strobes;
  int n_fail = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  // switch matrix: rows of the driven column
  always_comb begin
    rowSense = '0;
    for (int c = 0; c < KME_COLS; c++)
      for (int r = 0; r < KME_ROWS; r++)
        if (colDrive[c] && keys[c*KME_ROWS+r]) rowSense[r] = 1'b1;
  end
  kme_encoder #(.DEB_CYC(8), .SCAN_CYC(4)) kme_encoder_inst (.clk(clk), .rst(rst), .colDrive(colDrive),
    .rowSense(rowSense), .shiftKey(shiftKey), .controlKey(controlKey), .lockoutSel(lockoutSel),
    .keyPos(keyPos), .keyMode(keyMode), .dataReady(dataReady), .anyKeyDown(anyKeyDown));
  kme_host_model kme_host_model_inst (.clk(clk), .dataReady(dataReady), .keyPos(keyPos),
    .keyMode(keyMode), .strobes(strobes), .charIndex(charIndex));
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_strobes(input int n);
    for (int i = 0; i < 300 && strobes < n; i++) @(negedge clk);
    if (strobes < n) begin
      n_fail++;
      $display("ERROR strobe count expected %0d seen %0d", n, strobes);
    end
  endtask
  task automatic t_reset();
    check("reset code", 9'h000, {keyMode, keyPos});
    check("reset flags", 9'h000, {7'h00, dataReady, anyKeyDown});
    rst = 1'b0;
    idle(12);
    check("scan runs", 9'h001, {8'h00, colDrive !== 9'h001});
    $display("test reset done");
  endtask
  task automatic t_key(input int pos, input logic [1:0] mode);
    int s;
    s = strobes;
    shiftKey = mode[0];
    controlKey = mode[1];
    keys[pos] = 1'b1;
    wait_strobes(s + 1);
    check("code", {mode, pos[6:0]}, {keyMode, keyPos});
    check("host index", {mode, pos[6:0]}, charIndex);
    idle(150);
    check("anyKeyDown held", 9'h001, {8'h00, anyKeyDown});
    check("strobes", 9'(s + 1), 9'(strobes));
    keys[pos] = 1'b0;
    idle(90);
    check("anyKeyDown free", 9'h000, {8'h00, anyKeyDown});
    $display("test key %0d mode %0d done", pos, mode);
  endtask
  task automatic t_bounce();
    int s;
    s = strobes;
    keys[45] = 1'b1;
    idle(2);
    keys[45] = 1'b0;
    idle(200);
    check("bounce strobes", 9'(s), 9'(strobes));
    $display("test bounce done");
  endtask
  task automatic t_lockout(input logic sel);
    int s;
    s = strobes;
    shiftKey = 1'b0;
    controlKey = 1'b0;
    lockoutSel = sel;
    keys[20] = 1'b1;
    wait_strobes(s + 1);
    idle(80);
    keys[57] = 1'b1;
    idle(200);
    check("second key strobes", 9'(s + 2 - sel), 9'(strobes));
    if (!sel) check("second code", 9'd57, {keyMode, keyPos});
    keys = '0;
    idle(120);
    $display("test lockout %0d done", sel);
  endtask
  task automatic t_midreset();
    int s;
    s = strobes;
    keys[33] = 1'b1;
    wait_strobes(s + 1);
    check("held code", 9'd33, {keyMode, keyPos});
    rst = 1'b1;
    idle(2);
    check("mid reset code", 9'h000, {keyMode, keyPos});
    check("mid reset flags", 9'h000, {7'h00, dataReady, anyKeyDown});
    rst = 1'b0;
    wait_strobes(s + 2);
    check("code after reset", 9'd33, {keyMode, keyPos});
    keys = '0;
    idle(90);
    $display("test mid reset done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    report_and_stop();
  end
  initial begin
    idle(10);
    t_reset();
    t_key(0, KME_NORMAL);
    t_key(1, KME_SHIFT);
    t_key(10, KME_CONTROL);
    t_key(89, KME_SHIFT_CONTROL);
    t_bounce();
    t_lockout(1'b1);
    t_lockout(1'b0);
    t_midreset();
    report_and_stop();
  end
endmodule // keyboard_matrix_encoder_tb
